//--- rtl/echo_rx_params.svh
// constants for the echo receive stop control block
`ifndef ECHO_RX_PARAMS_SVH
`define ECHO_RX_PARAMS_SVH
`define GAIN_W 3
`define THLD_W 3
`define AZ_W 8
`define NUM_RX_W 3
`define AZ_DUR_RST 8'h10
`define START_NS 1000
`define CLK_NS 25
`define START_CYC (((`START_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define START_CYC_W 6
`define RECEIVE_MODE_SINGLE 1'h0
`define RECEIVE_MODE_MULTI 1'h1
`define LISTEN_MAX_W 16
`endif

//--- rtl/echo_rx_pkg.sv
// types for the echo receive stop control block
package echo_rx_pkg;
	typedef enum logic [2:0] {
		ST_SLEEP,
		ST_START,
		ST_AUTOZERO,
		ST_LISTEN,
		ST_DONE
	} seq_state_type;

	typedef struct packed {
		logic first_amp_feedback_select;
		logic first_amp_bypass;
		logic [2:0] second_stage_gain;
		logic second_stage_bypass;
		logic [2:0] echo_threshold_code;
	} receive_gain_config_reg_type;

	typedef struct packed {
		logic first_amp_cap_fb_en;
		logic first_amp_enable;
		logic first_amp_route_around;
		logic [7:0] second_stage_gain_onehot;
		logic second_stage_enable;
		logic second_stage_route_around;
		logic [7:0] threshold_dac_sel;
	} analog_ctrl_type;
endpackage : echo_rx_pkg

//--- rtl/stop_event_manager.sv
// stop pulse event manager: qualification and counting
`timescale 1ns/1ps
`include "echo_rx_params.svh"
module stop_event_manager (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clear_i,
	input wire logic enable_i,
	input wire logic receive_mode_i,
	input wire logic [`NUM_RX_W-1:0] num_rx_i,
	input wire logic threshold_hit_i,
	input wire logic zero_cross_i,
	output logic stop_o,
	output logic limit_reached_o
);
	logic qualified;
	logic [`NUM_RX_W:0] count;
	logic zc_prev;
	logic zc_rise;
	logic [`NUM_RX_W:0] limit;

	assign zc_rise = zero_cross_i & ~zc_prev;
	// single echo mode stops after one pulse
	assign limit = (receive_mode_i == `RECEIVE_MODE_SINGLE) ? {{`NUM_RX_W{1'b0}}, 1'b1} :
		{1'b0, num_rx_i};
	assign limit_reached_o = (count >= limit);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			zc_prev <= 1'b0;
		end else begin
			zc_prev <= zero_cross_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || clear_i) begin
			qualified <= 1'b0;
		end else if (enable_i && threshold_hit_i) begin
			qualified <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || clear_i) begin
			count <= '0;
			stop_o <= 1'b0;
		end else if (enable_i && qualified && zc_rise && !limit_reached_o) begin
			count <= count + 1'b1;
			stop_o <= 1'b1;
		end else begin
			stop_o <= 1'b0;
		end
	end

	// limit may be reprogrammed between cycles, so only bound it while listening
	a_count_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		enable_i |-> count <= limit) else $error("stop count over limit");
	a_stop_needs_qual: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(stop_o) |-> $past(qualified) && $past(enable_i)) else $error("unqualified stop");
	a_clear_resets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clear_i |=> count == '0 && !qualified && !stop_o) else $error("clear failed");
endmodule : stop_event_manager

//--- rtl/echo_receive_stop_control.sv
// receive chain control and measurement sequencer
`timescale 1ns/1ps
`include "echo_rx_params.svh"
// How it works
// - feedback bit 0 selects capacitive feedback
// - feedback bit 1 drops capacitor, resistive
// - first bypass disables and routes around
// - gain field picks 0 to 21 dB
// - second bypass disables and routes around
// - auto-zero runs at each receive start
// - auto-zero length from duration field
// - threshold code picks one of eight
// - stop pulses limited to programmed count in multiple mode, to one in single mode
// - mode bit picks single or multiple
// - threshold crossing while listening qualifies all later zero-crosses
// - qualified zero-cross emits stop pulse
// - trigger starts, device emits start pulse
// - after measurement return to sleep
module echo_receive_stop_control (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire echo_rx_pkg::receive_gain_config_reg_type receive_gain_config_reg_i,
	input wire logic [`AZ_W-1:0] offset_cancel_duration_i,
	input wire logic [`NUM_RX_W-1:0] num_rx_i,
	input wire logic receive_mode_i,
	input wire logic [`LISTEN_MAX_W-1:0] listen_timeout_i,
	input wire logic trigger_i,
	input wire logic threshold_hit_i,
	input wire logic zero_cross_i,
	output echo_rx_pkg::analog_ctrl_type analog_ctrl_o,
	output logic autozero_o,
	output logic start_o,
	output logic stop_o,
	output logic busy_o
);
	echo_rx_pkg::seq_state_type state;
	echo_rx_pkg::seq_state_type next_state;
	echo_rx_pkg::analog_ctrl_type next_ctrl;
	logic [`LISTEN_MAX_W-1:0] timer;
	logic [`LISTEN_MAX_W-1:0] next_timer;
	logic trig_prev;
	logic trig_rise;
	logic clear_em;
	logic em_enable;
	logic limit_reached;

	function automatic logic [7:0] onehot8(input logic [2:0] code);
		onehot8 = 8'h01 << code;
	endfunction : onehot8

	// ----------------------------------------
	// analog configuration decode
	// ----------------------------------------
	always_comb begin
		next_ctrl.first_amp_cap_fb_en = ~receive_gain_config_reg_i.first_amp_feedback_select;
		next_ctrl.first_amp_enable = ~receive_gain_config_reg_i.first_amp_bypass;
		next_ctrl.first_amp_route_around = receive_gain_config_reg_i.first_amp_bypass;
		next_ctrl.second_stage_gain_onehot =
			onehot8(receive_gain_config_reg_i.second_stage_gain);
		next_ctrl.second_stage_enable = ~receive_gain_config_reg_i.second_stage_bypass;
		next_ctrl.second_stage_route_around = receive_gain_config_reg_i.second_stage_bypass;
		next_ctrl.threshold_dac_sel = onehot8(receive_gain_config_reg_i.echo_threshold_code);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			analog_ctrl_o <= '0;
		end else begin
			analog_ctrl_o <= next_ctrl;
		end
	end

	// ----------------------------------------
	// measurement sequencer
	// ----------------------------------------
	assign trig_rise = trigger_i & ~trig_prev;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trigger_i;
		end
	end

	always_comb begin
		next_state = state;
		next_timer = timer;
		case (state)
			echo_rx_pkg::ST_SLEEP: begin
				if (trig_rise) begin
					next_state = echo_rx_pkg::ST_START;
					next_timer = '0;
				end
			end
			echo_rx_pkg::ST_START: begin
				if (timer == `LISTEN_MAX_W'(`START_CYC - 1)) begin
					next_state = echo_rx_pkg::ST_AUTOZERO;
					next_timer = '0;
				end else begin
					next_timer = timer + 1'b1;
				end
			end
			echo_rx_pkg::ST_AUTOZERO: begin
				// zero duration still gives one cycle
				if (timer[`AZ_W-1:0] + 1'b1 >= offset_cancel_duration_i) begin
					next_state = echo_rx_pkg::ST_LISTEN;
					next_timer = '0;
				end else begin
					next_timer = timer + 1'b1;
				end
			end
			echo_rx_pkg::ST_LISTEN: begin
				if (limit_reached || timer >= listen_timeout_i) begin
					next_state = echo_rx_pkg::ST_DONE;
				end else begin
					next_timer = timer + 1'b1;
				end
			end
			echo_rx_pkg::ST_DONE: begin
				next_state = echo_rx_pkg::ST_SLEEP;
			end
			default: begin
				next_state = echo_rx_pkg::ST_SLEEP;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= echo_rx_pkg::ST_SLEEP;
			timer <= '0;
		end else begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	assign start_o = (state == echo_rx_pkg::ST_START);
	assign autozero_o = (state == echo_rx_pkg::ST_AUTOZERO);
	assign busy_o = (state != echo_rx_pkg::ST_SLEEP);
	assign clear_em = (state == echo_rx_pkg::ST_START);
	assign em_enable = (state == echo_rx_pkg::ST_LISTEN);

	// ----------------------------------------
	// event manager
	// ----------------------------------------
	stop_event_manager u_events (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(clear_em),
		.enable_i(em_enable),
		.receive_mode_i(receive_mode_i),
		.num_rx_i(num_rx_i),
		.threshold_hit_i(threshold_hit_i),
		.zero_cross_i(zero_cross_i),
		.stop_o(stop_o),
		.limit_reached_o(limit_reached)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_trigger;
		state == echo_rx_pkg::ST_SLEEP && trig_rise;
	endsequence

	sequence s_start_then_az;
		start_o [*1] ##39 start_o ##1 autozero_o;
	endsequence

	sequence s_listen_expiry;
		state == echo_rx_pkg::ST_LISTEN && timer >= listen_timeout_i;
	endsequence

	sequence s_done_then_sleep;
		state == echo_rx_pkg::ST_DONE ##1 state == echo_rx_pkg::ST_SLEEP;
	endsequence

	a_trigger_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_trigger |=> s_start_then_az) else $error("start pulse wrong");
	a_az_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(autozero_o) && offset_cancel_duration_i == 8'h04 && $stable(offset_cancel_duration_i)
		|-> autozero_o [*4] ##1 !autozero_o) else $error("auto-zero length wrong");
	a_no_stop_az: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		autozero_o |=> !stop_o) else $error("stop during auto-zero");
	a_done_sleep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state == echo_rx_pkg::ST_DONE |=> !busy_o) else $error("no return to sleep");
	a_az_before_listen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(em_enable) |-> $past(autozero_o)) else $error("listen without auto-zero");
	a_listen_expiry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_listen_expiry |=> s_done_then_sleep) else $error("listen window overrun");
	// single echo ends the listen window right after its one stop
	a_single_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		receive_mode_i == `RECEIVE_MODE_SINGLE && $stable(receive_mode_i) && stop_o
		|=> state == echo_rx_pkg::ST_DONE) else $error("single echo overrun");

	// ----------------------------------------
	// configuration checks
	// ----------------------------------------
	a_fb_decode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(receive_gain_config_reg_i.first_amp_feedback_select) == 1'b0
		&& !$past(sys_rst_i) |-> analog_ctrl_o.first_amp_cap_fb_en) else $error("fb decode");
	a_fb_resistive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(receive_gain_config_reg_i.first_amp_feedback_select) == 1'b1
		&& !$past(sys_rst_i) |-> !analog_ctrl_o.first_amp_cap_fb_en)
		else $error("resistive fb decode");
	a_first_bypass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(receive_gain_config_reg_i.first_amp_bypass) && !$past(sys_rst_i)
		|-> analog_ctrl_o.first_amp_route_around && !analog_ctrl_o.first_amp_enable)
		else $error("first bypass decode");
	a_gain_onehot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) |-> $onehot(analog_ctrl_o.second_stage_gain_onehot)
		&& analog_ctrl_o.second_stage_gain_onehot[
			$past(receive_gain_config_reg_i.second_stage_gain)]) else $error("gain decode");
	a_thld_onehot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) |-> $onehot(analog_ctrl_o.threshold_dac_sel)
		&& analog_ctrl_o.threshold_dac_sel[
			$past(receive_gain_config_reg_i.echo_threshold_code)]) else $error("dac decode");
	a_bypass_pair: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(receive_gain_config_reg_i.second_stage_bypass) && !$past(sys_rst_i)
		|-> analog_ctrl_o.second_stage_route_around && !analog_ctrl_o.second_stage_enable)
		else $error("bypass pair");
endmodule : echo_receive_stop_control

//--- test/far_timer_model.sv
// far-side timer model: raises trigger, times start, counts stop pulses
`timescale 1ns/1ps
module far_timer_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic stop_i,
	output logic trigger_o
);
	int start_len = 0;
	int stop_cnt = 0;
	initial trigger_o = 1'h0;
	// ----------------------------------------
	// measurement request
	// ----------------------------------------
	task automatic fire();
		start_len = 0;
		stop_cnt = 0;
		@(posedge clk_i);
		trigger_o <= 1'h1;
		@(posedge clk_i);
		trigger_o <= 1'h0;
	endtask : fire
	// ----------------------------------------
	// reference and stop timing
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (start_i === 1'h1) start_len <= start_len + 1;
		if (stop_i === 1'h1) stop_cnt <= stop_cnt + 1;
	end
endmodule : far_timer_model

//--- test/testbench.sv
// self-checking bench for the echo receive stop control block
`timescale 1ns/1ps
`include "echo_rx_params.svh"
module testbench;
	logic clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	echo_rx_pkg::receive_gain_config_reg_type cfg = '0;
	echo_rx_pkg::analog_ctrl_type actl;
	logic [`AZ_W-1:0] dur = 8'h04;
	logic [`NUM_RX_W-1:0] nrx = 3'h2;
	logic mode = 1'h1;
	logic thr = 1'h0;
	logic zc = 1'h0;
	logic trig, az, start, stop, busy;
	int n_errors = 0;
	int num_checks = 0;
	int az_len = 0;
	int cyc = 0;
	initial forever #12.5 clk_i = ~clk_i;
	echo_receive_stop_control u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.receive_gain_config_reg_i(cfg), .offset_cancel_duration_i(dur),
		.num_rx_i(nrx), .receive_mode_i(mode), .listen_timeout_i(16'h00C8),
		.trigger_i(trig), .threshold_hit_i(thr), .zero_cross_i(zc),
		.analog_ctrl_o(actl), .autozero_o(az), .start_o(start), .stop_o(stop),
		.busy_o(busy));
	far_timer_model u_far (.clk_i(clk_i), .start_i(start), .stop_i(stop),
		.trigger_o(trig));
	// ----------------------------------------
	// compare, verdict, hang guard
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (az === 1'h1) az_len <= az_len + 1;
		if (cyc == 6000) begin
			n_errors++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// echo stimulus and measurement
	// ----------------------------------------
	task automatic pulse_zc();
		@(posedge clk_i) zc <= 1'h1;
		@(posedge clk_i) zc <= 1'h0;
	endtask : pulse_zc
	task automatic run(input logic m, input logic [2:0] n, input int exp_stops);
		int w;
		@(posedge clk_i);
		mode <= m;
		nrx <= n;
		az_len = 0;
		u_far.fire();
		for (w = 0; w < 100 && az !== 1'h1; w++) @(posedge clk_i);
		thr <= 1'h1;
		pulse_zc();
		thr <= 1'h0;
		for (w = 0; w < 300 && az === 1'h1; w++) @(posedge clk_i);
		pulse_zc();
		@(posedge clk_i) thr <= 1'h1;
		@(posedge clk_i) thr <= 1'h0;
		repeat (3) pulse_zc();
		for (w = 0; w < 400 && busy !== 1'h0; w++) @(posedge clk_i);
		check(16'(u_far.start_len), 16'(`START_CYC));
		check(16'(az_len), 16'h0004);
		check(16'(u_far.stop_cnt), 16'(exp_stops));
		check(16'(busy), 16'h0000);
		$display("measurement test done");
	endtask : run
	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			cfg <= '{i[0], i[1], i[2:0], i[2], 3'(7 - i)};
			repeat (2) @(posedge clk_i);
			#1;
			check(16'(actl.first_amp_cap_fb_en), 16'(!i[0]));
			check(16'({actl.first_amp_enable, actl.first_amp_route_around}),
				16'({!i[1], i[1]}));
			check(16'(actl.second_stage_gain_onehot), 16'h0001 << i);
			check(16'({actl.second_stage_enable, actl.second_stage_route_around}),
				16'({!i[2], i[2]}));
			check(16'(actl.threshold_dac_sel), 16'h0080 >> i);
		end
		$display("analog decode test done");
		run(1'h1, 3'h2, 2);
		run(1'h0, 3'h3, 1);
		run(1'h1, 3'h4, 3);
		wrap_up();
	end
endmodule : testbench
